// *** imtr_pkg.sv ***
// imtr_pkg.sv: constants, carrier structs and state types for the 10-bit read master
// assumes: the link clock runs at a 12 ns period and SCL at a 10 us period
package imtr_pkg;

  localparam int unsigned LINK_PERIOD_PS = 12000;
  localparam int unsigned SCL_PERIOD_NS  = 10000;
  // a quarter of an SCL period is a least time, so it rounds up
  localparam int unsigned QTR_CYCLES     =
    (SCL_PERIOD_NS * 1000 + 4 * LINK_PERIOD_PS - 1) / (4 * LINK_PERIOD_PS);
  localparam logic [7:0]  QTR_LAST       = 8'(QTR_CYCLES - 1);

  localparam logic [4:0]  TENBIT_PREFIX  = 5'h1E;
  localparam logic [3:0]  ACK_BIT        = 4'h8;
  localparam logic [3:0]  BIT_FIRST      = 4'h0;
  localparam int unsigned DATA_W         = 8;
  localparam int unsigned FIFO_DEPTH     = 8;

  typedef enum logic [2:0] {
    LK_IDLE,
    LK_START,
    LK_ADDR,
    LK_RXB,
    LK_WAIT,
    LK_HOLD,
    LK_STOP
  } imtr_st_t;

  // core to link levels, plus the bus pins, all synchronised together
  typedef struct packed {
    logic ce;
    logic start;
    logic stop;
    logic nak;
    logic ack_tg;
    logic scl;
    logic sda;
  } imtr_lk_in_t;

  // link to core events, each a toggle
  typedef struct packed {
    logic byte_tg;
    logic nack_tg;
    logic sta_tg;
    logic stp_tg;
  } imtr_ev_t;

  typedef struct packed {
    imtr_st_t    st;
    logic [1:0]  qtr;
    logic [7:0]  tick;
    logic [3:0]  bitn;
    logic [7:0]  sh;
    logic [7:0]  rxb;
    logic        sda_oe;
    logic        scl_oe;
    logic        ack_ok;
    logic        nak_sent;
    logic        ack_seen;
    imtr_ev_t    ev;
  } imtr_lk_t;

  typedef struct packed {
    logic        start;
    logic        stop;
    logic        nack_seen_flag;
    logic        rx_byte_full_flag;
    logic        ack_tg;
    logic        data_vld;
    logic        tx_irq;
    logic [7:0]  data;
    imtr_ev_t    ev_seen;
  } imtr_core_t;

  // idle is the first state, so all-zero is the idle reset value
  localparam imtr_lk_t   LK_RST   = imtr_lk_t'('0);
  localparam imtr_core_t CORE_RST = imtr_core_t'('0);

endpackage : imtr_pkg

// *** imtr_sync.sv ***
// imtr_sync.sv: three-flop synchroniser with a filter that waits for stages two and three to agree
// assumes: each bit is an independent level or toggle
`timescale 1ns/100ps
module imtr_sync #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         en_i,
  // levels
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] s1_q, s1_d;
  logic [W-1:0] s2_q, s2_d;
  logic [W-1:0] s3_q, s3_d;
  logic [W-1:0] out_q, out_d;

  always_comb begin
    s1_d  = en_i ? d_i : s1_q;
    s2_d  = en_i ? s1_q : s2_q;
    s3_d  = en_i ? s2_q : s3_q;
    // a bit moves only once stages two and three agree
    out_d = en_i ? (((s2_q ~^ s3_q) & s3_q) | ((s2_q ^ s3_q) & out_q)) : out_q;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      out_q <= '0;
    end else begin
      s1_q  <= s1_d;
      s2_q  <= s2_d;
      s3_q  <= s3_d;
      out_q <= out_d;
    end
  end

  assign q_o = out_q;

endmodule : imtr_sync

// *** imtr_fifo.sv ***
// imtr_fifo.sv: synchronous FIFO with valid/ready on both sides
// assumes: one clock; clr_i with en_i high empties it; en_i low freezes it and drops in_ready_o and out_valid_o
`timescale 1ns/100ps
module imtr_fifo #(
  parameter int unsigned W     = 8,
  parameter int unsigned DEPTH = 8
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         en_i,
  input  wire logic         clr_i,
  // fill side
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  // drain side
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic      [W-1:0] out_data_o
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [W-1:0] mem_q [DEPTH];
  logic [AW:0]  wr_q, wr_d;
  logic [AW:0]  rd_q, rd_d;
  logic         full;
  logic         empty;
  logic         push;
  logic         pop;

  always_comb begin
    full        = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
    empty       = (wr_q == rd_q);
    in_ready_o  = en_i && !full && !clr_i;
    out_valid_o = en_i && !empty && !clr_i;
    out_data_o  = mem_q[rd_q[AW-1:0]];
    push        = in_valid_i && in_ready_o;
    pop         = out_valid_o && out_ready_i;
    wr_d        = (en_i && clr_i) ? '0 : wr_q + {{AW{1'b0}}, push};
    rd_d        = (en_i && clr_i) ? '0 : rd_q + {{AW{1'b0}}, pop};
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
  end

  // storage needs no reset; it is read only where written
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data_i;
    end
  end

endmodule : imtr_fifo

// *** imtr_master.sv ***
// imtr_master.sv: I2C master tail of a 10-bit read: repeated START, third address
// byte, byte reception with ACK/NACK, STOP, and the data register with its flags.
// assumes: open-drain SCL/SDA resolved outside; software drives the control ports
// on CORE_CLK_I; LINK_CLK_I is a free-running clock, 836 cycles per SCL bit.
// Contract
// R1: after the second address byte a repeated START goes out first.
// R2: third address byte is copied from the data register into the shift register; the code takes only bits 2:1 from it and fixes the rest.
// R3: third address byte is 11110, two upper address bits, then 1 for read.
// R4: slave acknowledges the third address byte with SDA low during SCL high.
// R5: on a missing acknowledge software sets stop and flush, clears tx enable.
// R6: each byte shifts eight bits in, then NACK if last-byte select, else ACK.
// R7: a received byte sets the receive-full flag and raises the receive interrupt.
// R8: reading the data register clears the receive-full flag.
// R9: software sets last-byte select when exactly one byte remains.
// R10: reception repeats, software reading each byte, while bytes remain.
// R11: after the final byte with NACK a not-acknowledge interrupt is raised.
// R12: software answers the final NACK by setting the stop request bit.
// R13: stop request makes a STOP, then clears stop request and NACK flag.
// R14: data register feeds the shift register on writes, takes it on reads.
// R15: shift register has no software access, only buffers bits.
// R16: NACK flag clears only by start or stop request; engine waits till then.
// R17: receive-full sets in the ACK phase; engine stalls until it is cleared.
// R18: SDA changes mid SCL low, sampled mid SCL high, MSB first.
`timescale 1ns/100ps
module imtr_master
  import imtr_pkg::*;
(
  // clocks, reset, enable
  input  wire logic              CORE_CLK_I,
  input  wire logic              LINK_CLK_I,
  input  wire logic              ARST_N_I,
  input  wire logic              CE_I,
  // outgoing byte stream into the data register
  input  wire logic              TXD_VALID_I,
  input  wire logic [DATA_W-1:0] TXD_DATA_I,
  output logic                   TXD_READY_O,
  // control bits
  input  wire logic              STA_SET_I,
  input  wire logic              STP_SET_I,
  input  wire logic              NAK_I,
  input  wire logic              FLUSH_I,
  input  wire logic              TX_IRQ_ENABLE_I,
  input  wire logic              RD_I,
  // status
  output logic      [DATA_W-1:0] DATA_O,
  output logic                   START_O,
  output logic                   STOP_O,
  output logic                   RX_BYTE_FULL_FLAG_O,
  output logic                   NACK_SEEN_FLAG_O,
  output logic                   TX_IRQ_O,
  // bus pins
  input  wire logic              SCL_I,
  output logic                   SCL_O,
  output logic                   SCL_OE_O,
  input  wire logic              SDA_I,
  output logic                   SDA_O,
  output logic                   SDA_OE_O
);

  function automatic logic ack_slot(input logic [3:0] b);
    return b == ACK_BIT;
  endfunction : ack_slot

  imtr_core_t   core_q, core_d;
  imtr_lk_t     lk_q, lk_d;
  imtr_lk_in_t  lk_raw;
  imtr_lk_in_t  lk_in;
  imtr_ev_t     ev_c;
  imtr_ev_t     ev_new;
  logic         fifo_vld;
  logic         fifo_rdy;
  logic [7:0]   fifo_data;
  logic [1:0]   addr_hi;

  //////////////////////////////////////////////////////////////////////////////
  // crossings and the outgoing byte buffer

  imtr_fifo #(
    .W     (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (CORE_CLK_I),
    .rst_n_i     (ARST_N_I),
    .en_i        (CE_I),
    .clr_i       (FLUSH_I),
    .in_valid_i  (TXD_VALID_I),
    .in_ready_o  (TXD_READY_O),
    .in_data_i   (TXD_DATA_I),
    .out_valid_o (fifo_vld),
    .out_ready_i (fifo_rdy),
    .out_data_o  (fifo_data)
  );

  imtr_sync #(
    .W ($bits(imtr_ev_t))
  ) u_sync_core (
    .clk_i   (CORE_CLK_I),
    .rst_n_i (ARST_N_I),
    .en_i    (CE_I),
    .d_i     (lk_q.ev),
    .q_o     (ev_c)
  );

  // last-byte select crosses unregistered, so it reaches the link no later than the registered read toggle
  assign lk_raw = '{ce: CE_I, start: core_q.start, stop: core_q.stop, nak: NAK_I, // R9
                    ack_tg: core_q.ack_tg, scl: SCL_I, sda: SDA_I};

  imtr_sync #(
    .W ($bits(imtr_lk_in_t))
  ) u_sync_link (
    .clk_i   (LINK_CLK_I),
    .rst_n_i (ARST_N_I),
    .en_i    (1'b1),
    .d_i     (lk_raw),
    .q_o     (lk_in)
  );

  //////////////////////////////////////////////////////////////////////////////
  // core side: data register and flags

  always_comb begin
    core_d   = core_q;
    ev_new   = ev_c ^ core_q.ev_seen;
    // loads wait while a start is pending, so the link reads a still register
    fifo_rdy = CE_I && !core_q.data_vld && !core_q.rx_byte_full_flag && !core_q.start
               && !FLUSH_I && !ev_new.byte_tg;
    if (CE_I) begin
      core_d.ev_seen           = ev_c;
      core_d.start             = STA_SET_I || (core_q.start && !ev_new.sta_tg);
      core_d.stop              = STP_SET_I || (core_q.stop && !ev_new.stp_tg); // R13
      core_d.nack_seen_flag    = ev_new.nack_tg || (core_q.nack_seen_flag // R16
                                 && !(STA_SET_I || STP_SET_I || ev_new.stp_tg)); // R13
      core_d.rx_byte_full_flag = ev_new.byte_tg || (core_q.rx_byte_full_flag && !RD_I); // R7 R8
      if (RD_I && core_q.rx_byte_full_flag && !ev_new.byte_tg) begin
        core_d.ack_tg = ~core_q.ack_tg; // R10
      end
      if (ev_new.byte_tg) begin
        core_d.data     = lk_q.rxb; // R14
        core_d.data_vld = 1'b0;
      end else if (fifo_rdy && fifo_vld) begin
        core_d.data     = fifo_data; // R14
        core_d.data_vld = 1'b1;
      end else if (FLUSH_I || ev_new.sta_tg) begin
        core_d.data_vld = 1'b0;
      end
      core_d.tx_irq = TX_IRQ_ENABLE_I && !core_d.data_vld;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      core_q <= CORE_RST;
    end else begin
      core_q <= core_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // link side: bit engine, four quarters per SCL period

  assign addr_hi = core_q.data[2:1];

  always_comb begin
    lk_d = lk_q;
    if (lk_in.ce) begin
      unique case (lk_q.st)
        LK_IDLE: begin
          lk_d.sda_oe = 1'b0;
          lk_d.scl_oe = 1'b0;
          if (lk_in.start || lk_in.stop) begin
            lk_d.st     = lk_in.start ? LK_START : LK_STOP;
            lk_d.scl_oe = 1'b1;
            lk_d.qtr    = '0;
            lk_d.tick   = '0;
          end
        end
        LK_HOLD: begin
          // nothing moves until a stop or start request arrives
          if (lk_in.stop || lk_in.start) begin // R16 R12 R5
            lk_d.st   = lk_in.stop ? LK_STOP : LK_START;
            lk_d.qtr  = '0;
            lk_d.tick = '0;
          end
        end
        LK_WAIT: begin
          if (lk_in.ack_tg != lk_q.ack_seen) begin // R17
            lk_d.ack_seen = lk_in.ack_tg;
            lk_d.qtr      = '0;
            lk_d.tick     = '0;
            lk_d.bitn     = BIT_FIRST;
            if (lk_q.nak_sent) begin
              lk_d.st        = LK_HOLD;
              lk_d.ev.nack_tg = ~lk_q.ev.nack_tg; // R11
            end else begin
              lk_d.st = LK_RXB; // R10
            end
          end
        end
        LK_START, LK_ADDR, LK_RXB, LK_STOP: begin
          // a slave holding SCL low freezes the high phase
          if (!(lk_q.qtr == 2'h2 && !lk_in.scl)) begin
            lk_d.tick = lk_q.tick + 8'h01;
            if (lk_q.tick == QTR_LAST) begin
              lk_d.tick = '0;
              lk_d.qtr  = lk_q.qtr + 2'h1;
              unique case (lk_q.qtr)
                2'h0: begin // middle of SCL low
                  if (lk_q.st == LK_START) begin
                    lk_d.sda_oe = 1'b0;
                  end else if (lk_q.st == LK_STOP) begin
                    lk_d.sda_oe = 1'b1;
                  end else if (lk_q.st == LK_ADDR) begin
                    lk_d.sda_oe = ack_slot(lk_q.bitn) ? 1'b0 : !lk_q.sh[7]; // R18
                  end else if (ack_slot(lk_q.bitn)) begin
                    lk_d.sda_oe   = !lk_in.nak; // R6
                    lk_d.nak_sent = lk_in.nak; // R6
                  end else begin
                    lk_d.sda_oe = 1'b0;
                  end
                end
                2'h1: begin
                  lk_d.scl_oe = 1'b0;
                end
                2'h2: begin // middle of SCL high
                  if (lk_q.st == LK_START) begin
                    lk_d.sda_oe = 1'b1; // R1
                  end else if (lk_q.st == LK_STOP) begin
                    lk_d.sda_oe    = 1'b0; // R13
                    lk_d.ev.stp_tg = ~lk_q.ev.stp_tg; // R13
                  end else if (ack_slot(lk_q.bitn)) begin
                    lk_d.ack_ok = !lk_in.sda; // R4
                  end else begin
                    lk_d.sh = {lk_q.sh[6:0], lk_in.sda}; // R18 R15
                  end
                end
                2'h3: begin
                  lk_d.scl_oe = (lk_q.st != LK_STOP);
                  lk_d.bitn   = lk_q.bitn + 4'h1;
                  if (lk_q.st == LK_START) begin
                    lk_d.st        = LK_ADDR;
                    lk_d.bitn      = BIT_FIRST;
                    lk_d.nak_sent  = 1'b0;
                    lk_d.sh        = {TENBIT_PREFIX, addr_hi, 1'b1}; // R2 R3
                    lk_d.ev.sta_tg = ~lk_q.ev.sta_tg;
                  end else if (lk_q.st == LK_STOP) begin
                    lk_d.st = LK_IDLE;
                  end else if (ack_slot(lk_q.bitn)) begin
                    lk_d.bitn = BIT_FIRST;
                    if (lk_q.st == LK_RXB) begin
                      lk_d.rxb        = lk_q.sh; // R14 R15
                      lk_d.ev.byte_tg = ~lk_q.ev.byte_tg; // R7 R17
                      lk_d.st         = LK_WAIT;
                    end else if (lk_q.ack_ok) begin
                      lk_d.st = LK_RXB; // R4
                    end else begin
                      lk_d.st         = LK_HOLD;
                      lk_d.ev.nack_tg = ~lk_q.ev.nack_tg;
                    end
                  end
                end
              endcase
            end
          end
        end
        default: begin
          lk_d = LK_RST;
        end
      endcase
    end
  end

  always_ff @(posedge LINK_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      lk_q <= LK_RST;
    end else begin
      lk_q <= lk_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  assign DATA_O              = core_q.data;
  assign START_O             = core_q.start;
  assign STOP_O              = core_q.stop;
  assign RX_BYTE_FULL_FLAG_O = core_q.rx_byte_full_flag;
  assign NACK_SEEN_FLAG_O    = core_q.nack_seen_flag;
  assign TX_IRQ_O            = core_q.tx_irq;
  assign SCL_O               = 1'b0;
  assign SDA_O               = 1'b0;
  assign SCL_OE_O            = lk_q.scl_oe;
  assign SDA_OE_O            = lk_q.sda_oe;

  //////////////////////////////////////////////////////////////////////////////
  // assertions

  a_rstart_cond: assert property ( // R1
    @(posedge LINK_CLK_I) disable iff (!ARST_N_I)
    (lk_q.st == LK_START && lk_q.qtr == 2'h3) |-> (lk_q.sda_oe && !lk_q.scl_oe))
    else $error("start condition not held in last quarter");

  a_third_addr: assert property ( // R2 R3
    @(posedge LINK_CLK_I) disable iff (!ARST_N_I)
    (lk_q.st == LK_START && lk_d.st == LK_ADDR)
    |=> (lk_q.sh == {TENBIT_PREFIX, $past(addr_hi), 1'b1}) && lk_q.bitn == BIT_FIRST)
    else $error("third address byte malformed");

  a_ack_drive: assert property ( // R6
    @(posedge LINK_CLK_I) disable iff (!ARST_N_I)
    (lk_q.st == LK_RXB && ack_slot(lk_q.bitn) && lk_q.qtr == 2'h2)
    |-> (lk_q.sda_oe == !lk_q.nak_sent))
    else $error("acknowledge level does not match last-byte select");

  a_sda_high_stable: assert property ( // R18
    @(posedge LINK_CLK_I) disable iff (!ARST_N_I)
    ((lk_q.st == LK_ADDR || lk_q.st == LK_RXB) && lk_q.qtr == 2'h3) |-> $stable(lk_q.sda_oe))
    else $error("SDA moved while SCL high");

  a_rx_stall: assert property ( // R17
    @(posedge LINK_CLK_I) disable iff (!ARST_N_I)
    (lk_q.st == LK_WAIT && lk_in.ack_tg == lk_q.ack_seen) |=> (lk_q.st == LK_WAIT))
    else $error("engine left the receive stall without a read");

  a_last_nack: assert property ( // R11
    @(posedge LINK_CLK_I) disable iff (!ARST_N_I)
    (lk_q.st == LK_WAIT && lk_q.nak_sent && lk_d.st != LK_WAIT)
    |=> (lk_q.st == LK_HOLD) && $changed(lk_q.ev.nack_tg))
    else $error("final NACK did not raise the nack event");

  a_rx_set: assert property ( // R7 R14
    @(posedge CORE_CLK_I) disable iff (!ARST_N_I)
    (ev_new.byte_tg && CE_I)
    |=> core_q.rx_byte_full_flag && (core_q.data == $past(lk_q.rxb)))
    else $error("received byte not taken into the data register");

  a_rx_clear: assert property ( // R8
    @(posedge CORE_CLK_I) disable iff (!ARST_N_I)
    (RD_I && CE_I && !ev_new.byte_tg) |=> !core_q.rx_byte_full_flag)
    else $error("read did not clear the receive-full flag");

  a_nack_keep: assert property ( // R16
    @(posedge CORE_CLK_I) disable iff (!ARST_N_I)
    (core_q.nack_seen_flag && !STA_SET_I && !STP_SET_I && !ev_new.stp_tg)
    |=> core_q.nack_seen_flag)
    else $error("nack flag cleared without a start or stop request");

  a_stop_done: assert property ( // R13
    @(posedge CORE_CLK_I) disable iff (!ARST_N_I)
    (ev_new.stp_tg && CE_I && !STP_SET_I && !ev_new.nack_tg)
    |=> !core_q.stop && !core_q.nack_seen_flag)
    else $error("stop completion left stop or nack set");

  c_byte_read: cover property (
    @(posedge CORE_CLK_I) disable iff (!ARST_N_I)
    ev_new.byte_tg ##[1:50] RD_I);

  c_nack_seen: cover property (
    @(posedge CORE_CLK_I) disable iff (!ARST_N_I)
    $rose(core_q.nack_seen_flag));

  c_stop_done: cover property (
    @(posedge LINK_CLK_I) disable iff (!ARST_N_I)
    lk_q.st == LK_STOP ##1 lk_q.st == LK_IDLE);

endmodule : imtr_master

// *** imtr_slave.sv ***
// imtr_slave.sv: behavioural 10-bit-address I2C slave that answers a read
// assumes: the bench resolves the open-drain lines, both with pull-ups
`timescale 1ns/100ps
module imtr_slave #(
  parameter logic [1:0] ADDR_HI = 2'h2
) (
  // bus lines as resolved
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  // bytes to send, first byte lowest
  input  wire logic [31:0] bytes_i,
  // outputs
  output logic             sda_low_o,
  output logic [7:0]       addr_o,
  output logic             mnak_o,
  output logic             stop_o
);
  logic [7:0] sh;
  int         n;
  int         k;
  logic       fresh;
  logic       addr_ph;
  logic       rd_ok;
  initial begin
    {sda_low_o, mnak_o, stop_o, fresh, addr_ph, rd_ok} = 6'h00;
    n = 0;
    k = 0;
  end
  ////////////////////////////////////////
  // start and stop: SDA moving while SCL is high
  always @(negedge sda_i) if (scl_i) begin
    {n, k} = {32'sd0, -32'sd1};
    {fresh, addr_ph, rd_ok, mnak_o, stop_o} = 5'h18;
  end
  always @(posedge sda_i) if (scl_i) begin
    stop_o = 1'b1;
    {addr_ph, rd_ok} = 2'h0;
  end
  // sample in the high phase; a released ack slot ends our sending
  always @(posedge scl_i) begin
    if (n < 8) sh = {sh[6:0], sda_i};
    else if (!addr_ph && sda_i === 1'b1) begin
      mnak_o = 1'b1;
      rd_ok = 1'b0;
    end
  end
  // drive just after SCL falls, so SDA never moves while SCL is high
  always @(negedge scl_i) begin
    if (fresh) begin
      fresh = 1'b0;
      sda_low_o = 1'b0;
    end else begin
      n = (n == 8) ? 0 : n + 1;
      if (n == 0) k = k + 1;
      if (n == 0 && addr_ph) begin
        addr_ph = 1'b0;
        rd_ok = sda_low_o;
      end
      if (n == 8 && addr_ph) begin
        addr_o = sh;
        sda_low_o = (sh == {5'h1E, ADDR_HI, 1'b1});
      end else sda_low_o = rd_ok && n < 8 && !bytes_i[(8*k + 7 - n) % 32];
    end
  end
endmodule : imtr_slave

// *** imtr_master_bench.sv ***
// imtr_master_bench.sv: self-checking bench for the 10-bit read master
// assumes: imtr_slave on the far side, pull-ups on SCL and SDA
`timescale 1ns/100ps
module imtr_master_bench;
  import imtr_pkg::*;
  logic        clk = 1'b0;
  logic        lclk = 1'b0;
  logic        rst_n, txv, sta, stp, nak, flush, txen, rd;
  logic        ce = 1'b1;
  logic [7:0]  txd;
  logic [31:0] bytes;
  int          n_mismatch = 0;
  int          checks_done = 0;
  int          cnt;
  wire         scl_oe, sda_oe, sda_low, rxf, nkf, start_q, stop_q, ready, mnak, s_stop;
  wire         tx_irq;
  wire  [7:0]  data, addr;
  wire         scl = ~scl_oe;
  wire         sda = ~(sda_oe | sda_low);
  always #5 clk = ~clk;
  // link clock on its own phase
  initial begin
    #1.7;
    forever #6 lclk = ~lclk;
  end
  imtr_master uut (
    .CORE_CLK_I(clk), .LINK_CLK_I(lclk), .ARST_N_I(rst_n), .CE_I(ce),
    .TXD_VALID_I(txv), .TXD_DATA_I(txd), .TXD_READY_O(ready),
    .STA_SET_I(sta), .STP_SET_I(stp), .NAK_I(nak), .FLUSH_I(flush),
    .TX_IRQ_ENABLE_I(txen), .RD_I(rd), .DATA_O(data), .START_O(start_q),
    .STOP_O(stop_q), .RX_BYTE_FULL_FLAG_O(rxf), .NACK_SEEN_FLAG_O(nkf), .TX_IRQ_O(tx_irq),
    .SCL_I(scl), .SCL_O(), .SCL_OE_O(scl_oe), .SDA_I(sda), .SDA_O(), .SDA_OE_O(sda_oe));
  imtr_slave #(.ADDR_HI(2'h2)) peer (.scl_i(scl), .sda_i(sda), .bytes_i(bytes),
    .sda_low_o(sda_low), .addr_o(addr), .mnak_o(mnak), .stop_o(s_stop));
  ////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish
  // only bits 2:1 should reach the bus; the rest is noise
  task automatic push_addr(input logic [1:0] hi);
    txv = 1'b1;
    txd = {5'($urandom), hi, 1'($urandom)};
    tick(1);
    txv = 1'b0;
    tick(4);
    chk(tx_irq, 1'b0);
  endtask : push_addr
  task automatic end_stop;
    stp = 1'b1;
    tick(1);
    stp = 1'b0;
    chk(stop_q, 1'b1);
    for (cnt = 0; cnt < 1500 && stop_q !== 1'b0; cnt++) tick(1);
    chk(stop_q, 1'b0);
    chk(nkf, 1'b0);
    chk(s_stop, 1'b1);
  endtask : end_stop
  ////////////////////////////////////////
  initial begin
    repeat (100000) @(posedge clk);
    n_mismatch++;
    tally_and_finish;
  end
  initial begin
    {txv, sta, stp, nak, flush, rd} = 6'h00;
    txd = 8'h00;
    txen = 1'b1;
    rst_n = 1'b0;
    bytes = $urandom(32'h1BC13086);
    tick(3);
    rst_n = 1'b1;
    chk(data, 8'h00);
    chk(rxf, 1'b0);
    // matching slave, three bytes, the last one refused
    push_addr(2'h2);
    sta = 1'b1;
    tick(1);
    sta = 1'b0;
    chk(start_q, 1'b1);
    for (int k = 0; k < 3; k++) begin
      // the first byte also waits out the start and the address byte
      for (cnt = 0; cnt < 25000 && rxf !== 1'b1; cnt++) tick(1);
      chk(rxf, 1'b1);
      chk(tx_irq, 1'b1);
      chk(data, bytes[8*k +: 8]);
      chk(mnak, 1'(k == 2));
      if (k == 0) begin
        chk(addr, {5'h1E, 2'h2, 1'b1});
        tick(600);
        chk(scl_oe, 1'b1);
        chk(rxf, 1'b1);
        // enable low: a read is ignored and the FIFO refuses
        ce = 1'b0;
        rd = 1'b1;
        tick(1);
        rd = 1'b0;
        tick(20);
        chk(rxf, 1'b1);
        chk(ready, 1'b0);
        ce = 1'b1;
        tick(2);
      end
      nak = (k >= 1);
      rd = 1'b1;
      tick(1);
      rd = 1'b0;
      chk(rxf, 1'b0);
    end
    for (cnt = 0; cnt < 200 && nkf !== 1'b1; cnt++) tick(1);
    chk(nkf, 1'b1);
    nak = 1'b0;
    tick(600);
    chk(nkf, 1'b1);
    chk(scl_oe, 1'b1);
    end_stop;
    // wrong upper bits: fill the FIFO until it refuses, then abandon
    push_addr(2'h1);
    txv = 1'b1;
    for (cnt = 0; cnt < 20 && ready === 1'b1; cnt++) begin
      txd = 8'($urandom);
      tick(1);
    end
    txv = 1'b0;
    chk(8'(cnt), 8'(FIFO_DEPTH));
    sta = 1'b1;
    tick(1);
    sta = 1'b0;
    for (cnt = 0; cnt < 15000 && nkf !== 1'b1; cnt++) tick(1);
    chk(nkf, 1'b1);
    chk(addr, {5'h1E, 2'h1, 1'b1});
    flush = 1'b1;
    txen = 1'b0;
    end_stop;
    flush = 1'b0;
    tick(1);
    chk(ready, 1'b1);
    chk(tx_irq, 1'b0);
    tally_and_finish;
  end
endmodule : imtr_master_bench
